// ---- logic/host_port.sv ----
// Top of the parallel host register port: pin sampling, access sequencing,
// data bus drive, ready and alarm interrupt.
// Assumes a host that keeps the bus handshake; pins are asynchronous here.
`timescale 1ns/100ps
`default_nettype none

// Function
// - Strap low async timing, high sync timing.
// - Eight-bit index selects one register.
// - One eight-bit two-way data bus.
// - Accesses accepted only with select low.
// - Read strobe fall under select starts read.
// - Write strobe fall under select starts write.
// - Ready low marks access complete.
// - Alarm pulls interrupt low until cleared.
// - Reset pin low resets the port.
// - Drive data while read strobe, select low.
// - Ready low once read data valid.
// - Take write data, drivers off.
// - Ready low only after data stored.
// - Sync access done within two periods plus 5ns.
module host_port (
  // Clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       RESET,
  // Mode strap, bus clock and port reset pin
  input  wire logic       PMODE,
  input  wire logic       PCLK,
  input  wire logic       PIN_RESET_N,
  // Host bus control and address
  input  wire logic       CS_N,
  input  wire logic       RD_N,
  input  wire logic       WR_N,
  input  wire logic [7:0] ADDR,
  // Host data bus
  input  wire logic [7:0] D_IN,
  output logic      [7:0] D_OUT,
  output logic            D_OE_N,
  // Handshake and interrupt
  output logic            RDY_N,
  output logic            INT_N,
  // Channel alarm events
  input  wire logic [5:0] ALARM_EVT
);

  host_port_pkg::pins_s       raw;
  host_port_pkg::pins_s       pin;
  host_port_pkg::port_state_e state_q;
  host_port_pkg::port_state_e state_d;
  host_port_pkg::access_s     acc_q;
  host_port_pkg::access_s     acc_d;
  logic                       rd_prev_q;
  logic                       wr_prev_q;
  logic                       pclk_prev_q;
  logic                       rdy_n_q;
  logic                       rdy_n_d;
  logic                       oe_n_q;
  logic                       oe_n_d;
  logic                       int_n_q;
  logic                       int_n_d;
  logic [7:0]                 dout_q;
  logic [7:0]                 dout_d;
  logic                       rd_fall;
  logic                       wr_fall;
  logic                       pclk_rise;
  logic                       stb;
  logic                       rd_stb;
  logic                       wr_stb;
  logic [7:0]                 rdata;
  logic                       pend;

  // Gather the pins, turned active high.
  assign raw = '{pmode: PMODE, pclk: PCLK, rst: ~PIN_RESET_N, cs: ~CS_N,
                 rd: ~RD_N, wr: ~WR_N, addr: ADDR, data: D_IN};

  // Every pin passes two flip-flops before anything reads it.
  host_pin_sync u_sync (
    .clk    (CLK_SYS),
    .rst    (RESET),
    .raw    (raw),
    .synced (pin)
  );

  // Register storage and alarm state.
  host_reg_bank u_bank (
    .clk    (CLK_SYS),
    .rst    (RESET),
    .clr    (pin.rst),
    .addr   (acc_q.addr),
    .wdata  (pin.data),
    .wr_stb (wr_stb),
    .rd_stb (rd_stb),
    .rdata  (rdata),
    .alarm  (ALARM_EVT),
    .pend   (pend)
  );

  // Edges of the sampled strobes and of the bus clock.
  assign rd_fall   = pin.rd & ~rd_prev_q;
  assign wr_fall   = pin.wr & ~wr_prev_q;
  assign pclk_rise = pin.pclk & ~pclk_prev_q;

  // The strobe that belongs to the access in flight.
  assign stb = acc_q.wr ? pin.wr : pin.rd;

  // Access sequencer and output values.
  always_comb begin
    state_d = state_q;
    acc_d   = acc_q;
    rdy_n_d = rdy_n_q;
    dout_d  = dout_q;
    rd_stb  = 1'b0;
    wr_stb  = 1'b0;
    case (state_q)
      host_port_pkg::ST_IDLE: begin
        if (pin.cs && rd_fall) begin
          acc_d   = '{addr: pin.addr, wr: 1'b0};
          state_d = host_port_pkg::ST_WAIT;
        end else if (pin.cs && wr_fall) begin
          acc_d   = '{addr: pin.addr, wr: 1'b1};
          state_d = host_port_pkg::ST_WAIT;
        end
      end
      host_port_pkg::ST_WAIT: begin
        if (!pin.cs || !stb) begin
          state_d = pin.cs ? host_port_pkg::ST_HOLD : host_port_pkg::ST_IDLE;
        end else if (!pin.pmode || pclk_rise) begin
          wr_stb  = acc_q.wr;
          rd_stb  = ~acc_q.wr;
          if (!acc_q.wr) begin
            dout_d = rdata;
          end
          rdy_n_d = 1'b0;
          state_d = host_port_pkg::ST_DONE;
        end
      end
      host_port_pkg::ST_DONE: begin
        if (!pin.cs || !stb) begin
          rdy_n_d = 1'b1;
          state_d = pin.cs ? host_port_pkg::ST_HOLD : host_port_pkg::ST_IDLE;
        end
      end
      host_port_pkg::ST_HOLD: begin
        if (!pin.cs) begin
          state_d = host_port_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = host_port_pkg::ST_IDLE;
      end
    endcase
    if (pin.rst) begin
      state_d = host_port_pkg::ST_IDLE;
      rdy_n_d = 1'b1;
      rd_stb  = 1'b0;
      wr_stb  = 1'b0;
    end
  end

  // Drivers on only while select and read strobe are low and no write runs.
  always_comb begin
    oe_n_d  = ~(pin.cs & pin.rd & ~pin.wr & ~pin.rst);
    int_n_d = ~(pend & ~pin.rst);
  end

  // Registers of the sequencer; every output comes straight from here.
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      state_q     <= host_port_pkg::ST_IDLE;
      acc_q       <= '0;
      rd_prev_q   <= 1'b0;
      wr_prev_q   <= 1'b0;
      pclk_prev_q <= 1'b0;
      rdy_n_q     <= 1'b1;
      oe_n_q      <= 1'b1;
      int_n_q     <= 1'b1;
      dout_q      <= host_port_pkg::RST_REG;
    end else begin
      state_q     <= state_d;
      acc_q       <= acc_d;
      rd_prev_q   <= pin.rd;
      wr_prev_q   <= pin.wr;
      pclk_prev_q <= pin.pclk;
      rdy_n_q     <= rdy_n_d;
      oe_n_q      <= oe_n_d;
      int_n_q     <= int_n_d;
      dout_q      <= dout_d;
    end
  end

  assign D_OUT  = dout_q;
  assign D_OE_N = oe_n_q;
  assign RDY_N  = rdy_n_q;
  assign INT_N  = int_n_q;

  // Checks on the port, sampled on the system clock.
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);

  // An access that starts in asynchronous mode completes in bounded time.
  async_done_a: assert property (
    (state_q == host_port_pkg::ST_IDLE && pin.cs && !pin.rst && !pin.pmode
     && (rd_fall || wr_fall)) ##1 (pin.cs && stb && !pin.rst && !pin.pmode)
    |=> !RDY_N)
    else $error("async access did not complete in time");

  // In synchronous mode completion waits for a bus clock edge.
  sync_wait_a: assert property (
    (state_q == host_port_pkg::ST_WAIT && pin.pmode && !pclk_rise)
    |=> RDY_N)
    else $error("sync access completed without a bus clock edge");

  // Without select the sequencer never leaves idle.
  select_gate_a: assert property (
    (state_q == host_port_pkg::ST_IDLE && !pin.cs) |=>
    state_q == host_port_pkg::ST_IDLE)
    else $error("access started without select");

  // Read strobe edge under select starts an access.
  read_start_a: assert property (
    (state_q == host_port_pkg::ST_IDLE && pin.cs && rd_fall && !pin.rst)
    |=> state_q == host_port_pkg::ST_WAIT && !acc_q.wr
        && acc_q.addr == $past(pin.addr))
    else $error("read request not taken");

  // Write strobe edge under select starts a write access.
  write_start_a: assert property (
    (state_q == host_port_pkg::ST_IDLE && pin.cs && !rd_fall && wr_fall
     && !pin.rst) |=> state_q == host_port_pkg::ST_WAIT && acc_q.wr)
    else $error("write request not taken");

  // Data drivers are on only while select and read strobe were low.
  read_drive_a: assert property (
    !D_OE_N |-> $past(pin.cs && pin.rd))
    else $error("data bus driven outside a read");

  // A write store never coincides with driving the data bus.
  write_hiz_a: assert property (
    wr_stb |=> D_OE_N)
    else $error("data bus driven during a write");

  // Read data is on the bus when ready falls.
  read_data_a: assert property (
    rd_stb |=> !RDY_N && D_OUT == $past(rdata))
    else $error("ready fell without read data");

  // Ready falls on the edge the write is stored, not before.
  write_ready_a: assert property (
    $fell(RDY_N) |-> $past(wr_stb || rd_stb))
    else $error("ready fell without a stored access");

  // Releasing the strobe or select releases ready.
  release_a: assert property (
    (!RDY_N && (!pin.cs || !stb)) |=> RDY_N)
    else $error("ready held after release");

  // A pending enabled alarm pulls the interrupt low next cycle.
  alarm_int_a: assert property (
    (pend && !pin.rst) |=> !INT_N)
    else $error("interrupt not raised for pending alarm");

  // The reset pin returns ready and interrupt to idle.
  pin_reset_a: assert property (
    pin.rst |=> RDY_N && INT_N && D_OE_N)
    else $error("port reset pin ignored");

  // Ready stays low while the host still holds select and strobe.
  ready_stand_a: assert property (
    (!RDY_N && pin.cs && stb && !pin.rst)
    |=> !RDY_N)
    else $error("ready released while strobe held");

  // An access whose strobe or select goes before completion ends without ready.
  abort_quiet_a: assert property (
    (state_q == host_port_pkg::ST_WAIT && (!pin.cs || !stb))
    |=> RDY_N && state_q != host_port_pkg::ST_DONE)
    else $error("aborted access completed");

  // After an access no new one starts until select has gone high.
  hold_refuse_a: assert property (
    state_q == host_port_pkg::ST_HOLD
    |=> state_q != host_port_pkg::ST_WAIT)
    else $error("new access taken before select release");

  // Without a pending enabled alarm the interrupt is released.
  int_release_a: assert property (
    !pend |=> INT_N)
    else $error("interrupt held without pending alarm");

  // Main scenarios.
  read_done_c: cover property (rd_stb ##1 !RDY_N);
  write_done_c: cover property (wr_stb ##1 !RDY_N);
  sync_done_c: cover property (pin.pmode && (rd_stb || wr_stb));
  alarm_c: cover property ($fell(INT_N));
  abort_c: cover property (state_q == host_port_pkg::ST_WAIT && !stb);

endmodule : host_port

`default_nettype wire

// ---- logic/host_port_pkg.sv ----
// Shared constants and types of the parallel host register port.
// Assumes one system clock of 100 MHz; all host pins are asynchronous to it.
package host_port_pkg;

  // System clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 10;

  // Longest strobe-to-ready time in asynchronous mode, and its cycle count.
  localparam int T_ASYNC_RDY_NS = 65;
  localparam int ASYNC_RDY_CYC  = (T_ASYNC_RDY_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  T_ASYNC_RDY_NS / CLK_PERIOD_NS;

  // Extra margin beyond two bus clock periods in synchronous mode.
  localparam int T_SYNC_MARGIN_NS = 5;

  // Number of alarm channels behind the port.
  localparam int NUM_CH = 6;

  // Register indices with behaviour of their own.
  localparam logic [7:0] OFS_INT_EN   = 8'h60;
  localparam logic [7:0] OFS_INT_STAT = 8'h61;

  // Values after reset.
  localparam logic [5:0] RST_INT_EN   = 6'h00;
  localparam logic [5:0] RST_INT_STAT = 6'h00;
  localparam logic [7:0] RST_REG      = 8'h00;

  // Host pins, all turned active high.
  typedef struct packed {
    logic       pmode;
    logic       pclk;
    logic       rst;
    logic       cs;
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } pins_s;

  // One latched register access.
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
  } access_s;

  // Access sequencer states.
  typedef enum {ST_IDLE, ST_WAIT, ST_DONE, ST_HOLD} port_state_e;

endpackage : host_port_pkg

// ---- logic/host_pin_sync.sv ----
// Two-stage synchroniser for the whole group of host pins.
// Assumes the pins change freely with respect to the system clock.
`timescale 1ns/100ps
`default_nettype none

module host_pin_sync (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Pins in, pins out
  input  wire host_port_pkg::pins_s raw,
  output var   host_port_pkg::pins_s synced
);

  host_port_pkg::pins_s meta_q;
  host_port_pkg::pins_s meta_d;
  host_port_pkg::pins_s sync_q;
  host_port_pkg::pins_s sync_d;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_d = raw;
    sync_d = meta_q;
  end

  // Both stages clear to the idle pin state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign synced = sync_q;

endmodule : host_pin_sync

`default_nettype wire

// ---- logic/host_reg_bank.sv ----
// Register array of the host port with the alarm enable and alarm status.
// Assumes strobes are one-cycle pulses from the access sequencer.
`timescale 1ns/100ps
`default_nettype none

module host_reg_bank (
  // Clock and resets
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clr,
  // Access
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  // Alarms
  input  wire logic [5:0] alarm,
  output logic            pend
);

  logic [7:0] mem [0:255];
  logic [5:0] en_q;
  logic [5:0] en_d;
  logic [5:0] stat_q;
  logic [5:0] stat_d;

  // Enable and sticky status; a new alarm wins over a read-clear.
  always_comb begin
    en_d   = en_q;
    stat_d = stat_q;
    if (rd_stb && addr == host_port_pkg::OFS_INT_STAT) begin
      stat_d = '0;
    end
    if (wr_stb && addr == host_port_pkg::OFS_INT_EN) begin
      en_d = wdata[5:0];
    end
    stat_d = stat_d | alarm;
    if (clr) begin
      en_d   = host_port_pkg::RST_INT_EN;
      stat_d = host_port_pkg::RST_INT_STAT;
    end
  end

  // Control registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_q   <= host_port_pkg::RST_INT_EN;
      stat_q <= host_port_pkg::RST_INT_STAT;
    end else begin
      en_q   <= en_d;
      stat_q <= stat_d;
    end
  end

  // Plain storage for every other index.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 256; i++) begin
        mem[i] <= host_port_pkg::RST_REG;
      end
    end else if (wr_stb) begin
      mem[addr] <= wdata;
    end
  end

  // Direct decode of the eight-bit index.
  always_comb begin
    case (addr)
      host_port_pkg::OFS_INT_EN:   rdata = {2'b00, en_q};
      host_port_pkg::OFS_INT_STAT: rdata = {2'b00, stat_q};
      default:                     rdata = mem[addr];
    endcase
  end

  assign pend = |(stat_q & en_q);

endmodule : host_reg_bank

`default_nettype wire

// ---- dv/host_cpu_model.sv ----
// Behavioural model of the local processor that drives the host bus of the port.
// Assumes the bench calls access() and that pins move just after a falling clock edge.
`timescale 1ns/100ps
`default_nettype none

module host_cpu_model (
  // Clock and device answers
  input  wire logic       clk,
  input  wire logic       rdy_n,
  input  wire logic [7:0] d_out,
  input  wire logic       d_oe_n,
  // Host bus pins
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic            pclk,
  output logic      [7:0] addr,
  output logic      [7:0] d_in
);
  logic       drv = 1'b0;
  logic [7:0] wdat = 8'h00;
  logic [7:0] last = 8'h00;

  initial cs_n = 1'b1;
  initial rd_n = 1'b1;
  initial wr_n = 1'b1;
  initial pclk = 1'b0;
  initial addr = 8'h00;

  // Wire level: host, else device, else a floating bus that shows the inverse of its last value.
  assign d_in = drv ? wdat : (!d_oe_n ? d_out : ~last);

  // Remember the last level that someone drove.
  always @(posedge clk) if (drv || !d_oe_n) last <= d_in;

  // One access: index and select, write data, strobe, wait for ready, then release.
  task automatic access(input logic wr, input logic sel, input logic sync,
                        input logic [7:0] a, input logic [7:0] wd, input int hold,
                        output logic [7:0] rdat, output int lat, output logic oe_n,
                        output int rel);
    @(negedge clk);
    addr <= a;
    cs_n <= !sel;
    drv  <= wr;
    wdat <= wd;
    @(negedge clk);
    if (wr)
      wr_n <= 1'b0;
    else
      rd_n <= 1'b0;
    lat = 0;
    // The bus clock runs only inside an access, 160 ns a period.
    while (rdy_n !== 1'b0 && lat < 40) begin
      @(negedge clk);
      lat++;
      if (sync && lat % 8 == 0) pclk <= ~pclk;
    end
    rdat = d_in;
    oe_n = d_oe_n;
    repeat (hold) @(negedge clk);
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    drv  <= 1'b0;
    rel = 0;
    while (rdy_n !== 1'b1 && rel < 20) begin
      @(negedge clk);
      rel++;
    end
    cs_n <= 1'b1;
    pclk <= 1'b0;
    repeat (4) @(negedge clk);
  endtask : access
endmodule : host_cpu_model
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench of the parallel host register port.
// Assumes host_cpu_model drives the bus; the bench drives straps, resets and alarms.
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic       pmode = 1'b0;
  logic       pin_reset_n = 1'b1;
  logic [5:0] alarm_evt = 6'h00;
  logic       pclk, cs_n, rd_n, wr_n, d_oe_n, rdy_n, int_n;
  logic [7:0] addr, d_in, d_out, rd_v;
  logic       oe_v;
  int         lat_v, rel_v;
  int         num_errors = 0;
  int         checks_done = 0;

  host_port dut (.CLK_SYS(clk_sys), .RESET(reset), .PMODE(pmode), .PCLK(pclk),
                 .PIN_RESET_N(pin_reset_n), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
                 .ADDR(addr), .D_IN(d_in), .D_OUT(d_out), .D_OE_N(d_oe_n),
                 .RDY_N(rdy_n), .INT_N(int_n), .ALARM_EVT(alarm_evt));
  host_cpu_model host (.clk(clk_sys), .rdy_n(rdy_n), .d_out(d_out), .d_oe_n(d_oe_n),
                       .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .pclk(pclk),
                       .addr(addr), .d_in(d_in));

  // System clock of 100 MHz.
  always #5 clk_sys = ~clk_sys;

  // Compare a byte and count it.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk8

  // Compare a single bit and count it.
  task automatic chk1(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk1

  // One host access; also judges release of ready and of the data drivers.
  task automatic acc(input logic wr, input logic sel, input logic [7:0] a,
                     input logic [7:0] wd, input int hold);
    host.access(wr, sel, pmode, a, wd, hold, rd_v, lat_v, oe_v, rel_v);
    if (sel) chk1(rel_v <= 4, 1'b1, "ready release");
    chk1(d_oe_n, 1'b1, "drivers after access");
    if (sel) chk1(oe_v, wr, "drive state at ready");
  endtask : acc

  // Values right after reset.
  task automatic t_reset;
    chk1(rdy_n, 1'b1, "ready idle");
    chk1(int_n, 1'b1, "irq idle");
    chk1(d_oe_n, 1'b1, "drivers idle");
    chk8(d_out, 8'h00, "read data idle");
  endtask : t_reset

  // Asynchronous writes then reads at several indices, prompt and slow hosts.
  task automatic t_async;
    logic [7:0] idx [3];
    idx = '{8'h00, 8'h5a, 8'hff};
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, 1'b1, idx[i], idx[i] ^ 8'h3c, i * 3);
      chk1(lat_v <= 6, 1'b1, "write ready time");
    end
    for (int i = 0; i < 3; i++) begin
      acc(1'b0, 1'b1, idx[i], 8'h00, i * 3);
      chk1(lat_v <= 6, 1'b1, "read ready time");
      chk8(rd_v, idx[i] ^ 8'h3c, "read back");
    end
  endtask : t_async

  // Synchronous mode waits for the bus clock yet stays within two periods plus 5 ns.
  task automatic t_sync;
    pmode = 1'b1;
    repeat (4) @(negedge clk_sys);
    acc(1'b1, 1'b1, 8'h12, 8'ha5, 0);
    chk1(lat_v >= 8 && lat_v <= 32, 1'b1, "sync write time");
    acc(1'b0, 1'b1, 8'h12, 8'h00, 2);
    chk1(lat_v >= 8 && lat_v <= 32, 1'b1, "sync read time");
    chk8(rd_v, 8'ha5, "sync read back");
    // A host that never clocks the bus gets no ready, gives up and stores nothing.
    host.access(1'b1, 1'b1, 1'b0, 8'h12, 8'h5e, 0, rd_v, lat_v, oe_v, rel_v);
    chk1(lat_v == 40, 1'b1, "no ready without bus clock");
    acc(1'b0, 1'b1, 8'h12, 8'h00, 0);
    chk8(rd_v, 8'ha5, "nothing stored on abort");
    pmode = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask : t_sync

  // A strobe without select is ignored and stores nothing.
  task automatic t_refuse;
    acc(1'b1, 1'b0, 8'h00, 8'hee, 0);
    chk1(lat_v == 40, 1'b1, "no ready unselected");
    acc(1'b0, 1'b1, 8'h00, 8'h00, 0);
    chk8(rd_v, 8'h3c, "unchanged after refusal");
  endtask : t_refuse

  // Enabled alarm pulls the interrupt low until the status is read; masked alarm does not.
  task automatic t_irq;
    acc(1'b1, 1'b1, 8'h60, 8'h01, 0);
    alarm_evt = 6'h01;
    @(negedge clk_sys);
    alarm_evt = 6'h00;
    repeat (4) @(negedge clk_sys);
    chk1(int_n, 1'b0, "irq on alarm");
    acc(1'b0, 1'b1, 8'h61, 8'h00, 0);
    chk8(rd_v & 8'h01, 8'h01, "status bit");
    chk1(int_n, 1'b1, "irq released");
    acc(1'b0, 1'b1, 8'h61, 8'h00, 0);
    chk8(rd_v & 8'h01, 8'h00, "status cleared");
    alarm_evt = 6'h02;
    @(negedge clk_sys);
    alarm_evt = 6'h00;
    repeat (4) @(negedge clk_sys);
    chk1(int_n, 1'b1, "masked alarm");
  endtask : t_irq

  // Port reset pin clears the enable but keeps plain storage.
  task automatic t_pin_reset;
    pin_reset_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    pin_reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    acc(1'b0, 1'b1, 8'h60, 8'h00, 0);
    chk8(rd_v, 8'h00, "enable after pin reset");
    acc(1'b0, 1'b1, 8'h5a, 8'h00, 0);
    chk8(rd_v, 8'h66, "storage kept");
  endtask : t_pin_reset

  // Verdict and end of run.
  task automatic report_and_stop;
    if (num_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // Main sequence.
  initial begin
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    repeat (3) @(negedge clk_sys);
    t_reset();
    t_async();
    t_sync();
    t_refuse();
    t_irq();
    t_pin_reset();
    report_and_stop();
  end

  // Watchdog well beyond the expected run of some 370 cycles.
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
